//--- inc/standby_map.vh
// Purpose: register offsets, field positions, reset values and counts of the standby block
// Assumes: word addressed register port, 16-bit registers
// Notes: included by the standby controller only
`ifndef STANDBY_MAP_VH
`define STANDBY_MAP_VH

// ==========================================
// register offsets
`define BLK_CTRL_ADDR 4'h0
`define STBY_CTRL_ADDR 4'h1
`define STBY_STAT_ADDR 4'h2

// ==========================================
// block control fields
`define BLK_SA_ADC_BIT 0
`define BLK_RC_ADC_BIT 1
`define BLK_VLS_BIT 9
`define BLK_LLD_BIT 10
`define BLK_CTRL_MASK 16'h0603
`define BLK_CTRL_RESET 16'h0400

// ==========================================
// standby control fields
`define STBY_HALT_BIT 0
`define STBY_DEEP_BIT 1
`define STBY_HALTH_BIT 2

// ==========================================
// restart counts
`define LS_START_COUNT 29
`define HS_RC_COUNT 512
`define HS_XTAL_COUNT 4096
`define HS_EXT_COUNT 128

// ==========================================
// high-speed clock modes
`define HS_MODE_RC 2'h0
`define HS_MODE_XTAL 2'h1
`define HS_MODE_EXT 2'h2

`endif

//--- core/standby_ctrl.v
// Purpose: block disable bits and HALT / DEEP-HALT / HALT-H standby sequencer
// Assumes: one clock, synchronous reset, event pulses from clock generator one cycle long
// Notes: the falling-edge release is modelled as the next enabled system clock cycle
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`include "standby_map.vh"

module standby_ctrl #(
	parameter XTAL_COUNT = `HS_XTAL_COUNT
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// register port
	input wire [3:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [15:0] rdata_o,
	// block write strobes from the peripheral bus
	input wire sa_adc_wr_i,
	input wire rc_adc_wr_i,
	input wire vls_wr_i,
	input wire lld_wr_i,
	// block controls
	output wire sa_adc_rst_o,
	output wire rc_adc_rst_o,
	output wire vls_rst_o,
	output wire lld_rst_o,
	output wire sa_adc_clk_en_o,
	output wire rc_adc_clk_en_o,
	output wire vls_clk_en_o,
	output wire lld_clk_en_o,
	output wire sa_adc_wr_o,
	output wire rc_adc_wr_o,
	output wire vls_wr_o,
	output wire lld_wr_o,
	// interrupt side
	input wire wdt_irq_i,
	input wire [6:0] irq_pend_i,
	input wire [6:0] irq_en_i,
	input wire master_int_enable_i,
	output wire int_accept_o,
	// clock generator side
	input wire hs_select_i,
	input wire [1:0] hs_mode_i,
	input wire ls_tick_i,
	input wire hs_src_tick_i,
	input wire hs_osc_start_time_i,
	output wire cpu_run_o,
	output wire periph_run_o,
	output wire ls_only_run_o,
	output wire sys_on_hs_o,
	output wire hs_rc_on_o,
	output wire hs_src_on_o,
	output wire hs_clk_valid_o,
	output wire hs_on_ext_src_o
);

// ==========================================
// states
localparam ST_RUN = 7'h01;
localparam ST_HALT = 7'h02;
localparam ST_DEEP = 7'h04;
localparam ST_HALTH = 7'h08;
localparam ST_LSWAIT = 7'h10;
localparam ST_RCWAIT = 7'h20;
localparam ST_SRCWAIT = 7'h40;

reg [15:0] blk_r;
reg [2:0] req_r;
reg [6:0] state_r;
reg [6:0] state_nxt;
reg [12:0] cnt_r;
reg [12:0] cnt_nxt;
reg hs_saved_r;
reg ext_src_r;
reg src_wait_r;
reg xtal_started_r;
reg [12:0] src_cnt_r;

// wake sources: watchdog always, others only when their enable is set
wire wake = wdt_irq_i | (|(irq_pend_i & irq_en_i));
wire wr_stby = wr_i && addr_i == `STBY_CTRL_ADDR;

// the parameter is 32 bits wide; only the low bits reach the counter
wire [31:0] xtal_full = XTAL_COUNT - 1;
wire [12:0] xtal_last = xtal_full[12:0];

// ==========================================
// block control register
always @(posedge clk_i) begin
	if (rst_i) begin
		blk_r <= `BLK_CTRL_RESET;
	end else if (ce_i && wr_i && addr_i == `BLK_CTRL_ADDR) begin
		blk_r <= wdata_i & `BLK_CTRL_MASK;
	end
end

// held in reset, clock off, writes blocked while disabled
assign sa_adc_rst_o = blk_r[`BLK_SA_ADC_BIT];
assign rc_adc_rst_o = blk_r[`BLK_RC_ADC_BIT];
assign vls_rst_o = blk_r[`BLK_VLS_BIT];
assign lld_rst_o = blk_r[`BLK_LLD_BIT];
assign sa_adc_clk_en_o = ~blk_r[`BLK_SA_ADC_BIT];
assign rc_adc_clk_en_o = ~blk_r[`BLK_RC_ADC_BIT];
assign vls_clk_en_o = ~blk_r[`BLK_VLS_BIT];
assign lld_clk_en_o = ~blk_r[`BLK_LLD_BIT];
assign sa_adc_wr_o = sa_adc_wr_i & ~blk_r[`BLK_SA_ADC_BIT];
assign rc_adc_wr_o = rc_adc_wr_i & ~blk_r[`BLK_RC_ADC_BIT];
assign vls_wr_o = vls_wr_i & ~blk_r[`BLK_VLS_BIT];
assign lld_wr_o = lld_wr_i & ~blk_r[`BLK_LLD_BIT];

// ==========================================
// standby sequencer
// one-hot codes keep every state decode to a single compare.
// the counter is shared by the low-speed and RC waits,
// which never overlap, so one 13-bit register covers both.
// limitation: the low-speed count is fixed; only the crystal
// count is a parameter, so benches may shorten that wait alone.
// a wake event seen while entering a stop mode is not lost:
// it is a level and is acted on in the first stop cycle.

always @* begin
	state_nxt = state_r;
	cnt_nxt = cnt_r;
	case (state_r)
		ST_RUN: begin
			cnt_nxt = 13'h0000;
			// lowest bit wins if software sets several at once
			if (wr_stby && wdata_i[`STBY_HALT_BIT]) begin
				state_nxt = ST_HALT;
			end else if (wr_stby && wdata_i[`STBY_DEEP_BIT]) begin
				state_nxt = ST_DEEP;
			end else if (wr_stby && wdata_i[`STBY_HALTH_BIT]) begin
				state_nxt = ST_HALTH;
			end
		end
		ST_HALT: begin
			if (wake) begin
				state_nxt = ST_RUN;
			end
		end
		ST_DEEP, ST_HALTH: begin
			if (wake) begin
				// low-speed wake returns at once, high speed waits for restart
				state_nxt = hs_saved_r ? ST_LSWAIT : ST_RUN;
			end
		end
		ST_LSWAIT: begin
			if (ls_tick_i) begin
				cnt_nxt = cnt_r + 13'h0001;
				if (cnt_r == `LS_START_COUNT - 1) begin
					state_nxt = ST_RCWAIT;
					cnt_nxt = 13'h0000;
				end
			end
		end
		ST_RCWAIT: begin
			if (ls_tick_i) begin
				cnt_nxt = cnt_r + 13'h0001;
				if (cnt_r == `HS_RC_COUNT - 1) begin
					state_nxt = ST_RUN;
					cnt_nxt = 13'h0000;
				end
			end
		end
		default: begin
			state_nxt = ST_RUN;
		end
	endcase
end

always @(posedge clk_i) begin
	if (rst_i) begin
		state_r <= ST_RUN;
		cnt_r <= 13'h0000;
		req_r <= 3'h0;
		hs_saved_r <= 1'b0;
	end else if (ce_i) begin
		state_r <= state_nxt;
		cnt_r <= cnt_nxt;
		if (state_r == ST_RUN) begin
			hs_saved_r <= hs_select_i;
		end
		// request bit stands until the wake event clears it
		if (state_nxt == ST_HALT) begin
			req_r <= 3'h1;
		end else if (state_nxt == ST_DEEP) begin
			req_r <= 3'h2;
		end else if (state_nxt == ST_HALTH) begin
			req_r <= 3'h4;
		end else begin
			req_r <= 3'h0;
		end
	end
end

// ==========================================
// source switch-over after RC supply
// counting starts once the low-speed wait is over, so the
// crystal or external source never takes over before the RC
// oscillator has been supplied.

always @(posedge clk_i) begin
	if (rst_i) begin
		src_wait_r <= 1'b0;
		xtal_started_r <= 1'b0;
		ext_src_r <= 1'b0;
	end else if (ce_i) begin
		if (state_r == ST_LSWAIT) begin
			src_wait_r <= hs_mode_i != `HS_MODE_RC;
			xtal_started_r <= 1'b0;
			ext_src_r <= 1'b0;
		end else if (src_wait_r && state_r != ST_DEEP && state_r != ST_HALTH) begin
			if (hs_mode_i == `HS_MODE_XTAL && hs_osc_start_time_i) begin
				xtal_started_r <= 1'b1;
			end
			if (hs_src_tick_i && (hs_mode_i == `HS_MODE_EXT || xtal_started_r)) begin
				if ((hs_mode_i == `HS_MODE_EXT && src_cnt_r == `HS_EXT_COUNT - 1) ||
					(hs_mode_i == `HS_MODE_XTAL && src_cnt_r == xtal_last)) begin
					src_wait_r <= 1'b0;
					ext_src_r <= 1'b1;
				end
			end
		end
	end
end

// source tick counter, cleared while idle so each wake starts afresh
always @(posedge clk_i) begin
	if (rst_i) begin
		src_cnt_r <= 13'h0000;
	end else if (ce_i) begin
		if (!src_wait_r || state_r == ST_LSWAIT) begin
			src_cnt_r <= 13'h0000;
		end else if (hs_src_tick_i && (hs_mode_i == `HS_MODE_EXT || xtal_started_r)) begin
			src_cnt_r <= src_cnt_r + 13'h0001;
		end
	end
end

// ==========================================
// outputs
wire stopped = state_r != ST_RUN;
assign cpu_run_o = ~stopped;
assign periph_run_o = state_r == ST_RUN || state_r == ST_HALT;
assign ls_only_run_o = state_r == ST_HALTH;
assign sys_on_hs_o = hs_select_i && state_r == ST_RUN;
assign hs_rc_on_o = state_r == ST_RCWAIT || (hs_select_i && state_r == ST_RUN) ||
	state_r == ST_HALT;
assign hs_src_on_o = src_wait_r | ext_src_r;
assign hs_clk_valid_o = state_r == ST_RUN || state_r == ST_HALT;
assign hs_on_ext_src_o = ext_src_r;
// non-watchdog interrupts only enter with master enable; watchdog without it; neither while stopped
assign int_accept_o = ~stopped && (wdt_irq_i ||
	(master_int_enable_i && |(irq_pend_i & irq_en_i)));

// ==========================================
// read back
always @(posedge clk_i) begin
	if (rst_i) begin
		rdata_o <= 16'h0000;
	end else if (ce_i) begin
		rdata_o <= 16'h0000;
		if (rd_i) begin
			case (addr_i)
				`BLK_CTRL_ADDR: rdata_o <= blk_r;
				`STBY_CTRL_ADDR: rdata_o <= {13'h0000, req_r};
				// software polls this before a stop request
				`STBY_STAT_ADDR: rdata_o <= {7'h00, state_r, ext_src_r, src_wait_r};
				default: rdata_o <= 16'h0000;
			endcase
		end
	end
end

endmodule // standby_ctrl

//--- testbench/standby_ctrl_props.sv
// Purpose: port-level checks of the standby block
// Assumes: bound to standby_ctrl, ce_i high in the bench
// Notes: sequencer timing is judged by the bench
`timescale 1ns/10ps
module standby_ctrl_props (
	input wire clk_i, input wire rst_i, input wire ce_i, input wire wr_i,
	input wire [3:0] addr_i, input wire [15:0] wdata_i,
	input wire sa_adc_rst_o, input wire rc_adc_rst_o, input wire vls_rst_o, input wire lld_rst_o,
	input wire sa_adc_clk_en_o, input wire sa_adc_wr_o, input wire cpu_run_o,
	input wire periph_run_o, input wire wdt_irq_i, input wire master_int_enable_i,
	input wire int_accept_o
);
	// ==========================================
	// helpers
	wire w0 = wr_i && ce_i && addr_i == 4'h0;
	wire w1 = wr_i && ce_i && addr_i == 4'h1 && cpu_run_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================
	// assertions
	a_sa_write: assert property (w0 |=> sa_adc_rst_o == $past(wdata_i[0]))
		else $error("sa disable bit not applied");
	a_rc_write: assert property (w0 |=> rc_adc_rst_o == $past(wdata_i[1]))
		else $error("rc disable bit not applied");
	a_vls_write: assert property (w0 |=> vls_rst_o == $past(wdata_i[9]))
		else $error("supervisor disable bit not applied");
	a_lld_write: assert property (w0 |=> lld_rst_o == $past(wdata_i[10]))
		else $error("detector disable bit not applied");
	a_gate_block: assert property (sa_adc_rst_o |-> !sa_adc_clk_en_o && !sa_adc_wr_o)
		else $error("disabled block still clocked or written");
	a_halt_enter: assert property (w1 && wdata_i[2:0] == 3'h1 |=> !cpu_run_o && periph_run_o)
		else $error("halt entry wrong");
	a_deep_enter: assert property (w1 && wdata_i[2:0] == 3'h2 |=> !cpu_run_o && !periph_run_o)
		else $error("deep halt entry wrong");
	a_halth_enter: assert property (w1 && wdata_i[2:0] == 3'h4 |=> !cpu_run_o)
		else $error("halt-h entry wrong");
	a_int_master: assert property (int_accept_o && !wdt_irq_i |-> master_int_enable_i)
		else $error("interrupt taken without master enable");
	c_request: cover property (w1);
	c_wake: cover property (!cpu_run_o ##1 cpu_run_o);
	c_accept: cover property (int_accept_o);
endmodule // standby_ctrl_props
bind standby_ctrl standby_ctrl_props chk (.clk_i, .rst_i, .ce_i, .wr_i, .addr_i, .wdata_i,
	.sa_adc_rst_o, .rc_adc_rst_o, .vls_rst_o, .lld_rst_o, .sa_adc_clk_en_o, .sa_adc_wr_o,
	.cpu_run_o, .periph_run_o, .wdt_irq_i, .master_int_enable_i, .int_accept_o);

//--- testbench/clk_gen_model.sv
// Purpose: clock generator stand-in giving count ticks and crystal start pulse
// Assumes: low-speed count every 4 cycles, source count every 2
// Notes: start pulse repeats while the source stays on
`timescale 1ns/10ps
module clk_gen_model (
	input wire clk_i,
	input wire rst_i,
	input wire osc_on_i,
	output reg ls_tick_o,
	output reg src_tick_o,
	output reg start_o
);
	reg [1:0] div_r;
	reg [3:0] st_r;
	always @(posedge clk_i) begin
		if (rst_i) begin
			div_r <= 2'h0;
			st_r <= 4'h0;
			ls_tick_o <= 1'b0;
			src_tick_o <= 1'b0;
			start_o <= 1'b0;
		end else begin
			div_r <= div_r + 2'h1;
			ls_tick_o <= div_r == 2'h0;
			src_tick_o <= div_r[0];
			start_o <= osc_on_i && st_r == 4'hE;
			st_r <= osc_on_i ? st_r + 4'h1 : 4'h0;
		end
	end
endmodule // clk_gen_model

//--- testbench/standby_block_power_control_tb.sv
// Purpose: self-checking bench of the standby block
// Assumes: crystal count shortened to 8
// Notes: the external-source status flag is still set from the deep-halt wake when HALT-H is requested
`timescale 1ns/10ps
module standby_block_power_control_tb;
	reg clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, bw = 1'b0, wdt = 1'b0;
	reg master_int_enable = 1'b0, hsel = 1'b0;
	reg [3:0] addr = 4'h0;
	reg [15:0] wd = 16'h0000, v;
	reg [6:0] pend = 7'h00, ien = 7'h00;
	reg [1:0] mode = 2'h0;
	wire [15:0] rdata;
	wire [3:0] brst, bclk, bwo;
	wire ls_t, hs_t, st_t, run, prun, acc, shs, hsrc, ext, lso, rco, hcv;
	integer error_cnt = 0, compares = 0, cyc = 0, n;
	standby_ctrl #(.XTAL_COUNT(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr),
		.wdata_i(wd), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .sa_adc_wr_i(bw), .rc_adc_wr_i(bw),
		.vls_wr_i(bw), .lld_wr_i(bw), .sa_adc_rst_o(brst[0]), .rc_adc_rst_o(brst[1]),
		.vls_rst_o(brst[2]), .lld_rst_o(brst[3]), .sa_adc_clk_en_o(bclk[0]),
		.rc_adc_clk_en_o(bclk[1]), .vls_clk_en_o(bclk[2]), .lld_clk_en_o(bclk[3]),
		.sa_adc_wr_o(bwo[0]), .rc_adc_wr_o(bwo[1]), .vls_wr_o(bwo[2]), .lld_wr_o(bwo[3]),
		.wdt_irq_i(wdt), .irq_pend_i(pend), .irq_en_i(ien), .master_int_enable_i(master_int_enable),
		.int_accept_o(acc), .hs_select_i(hsel), .hs_mode_i(mode), .ls_tick_i(ls_t),
		.hs_src_tick_i(hs_t), .hs_osc_start_time_i(st_t), .cpu_run_o(run), .periph_run_o(prun),
		.ls_only_run_o(lso), .sys_on_hs_o(shs), .hs_rc_on_o(rco), .hs_src_on_o(hsrc),
		.hs_clk_valid_o(hcv), .hs_on_ext_src_o(ext));
	clk_gen_model gen (.clk_i(clk_i), .rst_i(rst_i), .osc_on_i(hsrc), .ls_tick_o(ls_t),
		.src_tick_o(hs_t), .start_o(st_t));
	initial forever #5 clk_i = ~clk_i;
	// ==========================================
	// shared tasks
	task test_done;
	begin
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	end
	endtask
	// hang guard well above the longest wake sequence
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			test_done;
		end
	end
	task chk(input [15:0] got, input [15:0] exp);
	begin
		compares = compares + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [3:0] a, input [15:0] d);
	begin
		@(posedge clk_i); addr <= a; wd <= d; wr_i <= 1'b1;
		@(posedge clk_i); wr_i <= 1'b0;
	end
	endtask
	task rd(input [3:0] a);
	begin
		@(posedge clk_i); addr <= a; rd_i <= 1'b1;
		@(posedge clk_i); rd_i <= 1'b0;
		#1 v = rdata;
	end
	endtask
	task wake;
	begin
		n = 0;
		while (run !== 1'b1 && n < 3000) begin @(posedge clk_i); #1 n = n + 1; end
	end
	endtask
	task wait_ext;
	begin
		n = 0;
		while (ext !== 1'b1 && n < 600) begin @(posedge clk_i); #1 n = n + 1; end
		chk({15'h0000, ext}, 16'h0001);
	end
	endtask
	// ==========================================
	// scenarios
	task t_blocks;
	begin
		rd(4'h0);
		chk(v, 16'h0400);
		chk({12'h000, brst, bwo}, 16'h0087);
		wr(4'h0, 16'h0603);
		rd(4'h0);
		chk(v, 16'h0603);
		chk({8'h00, brst, bclk, bwo}, 16'h0F00);
		wr(4'h0, 16'h0000);
		#1 chk({12'h000, bclk, bwo}, 16'h00FF);
		rd(4'hF);
		chk(v, 16'h0000);
	end
	endtask
	task t_halt;
	begin
		wr(4'h1, 16'h0001);
		#1 chk({14'h0000, run, prun}, 16'h0001);
		rd(4'h1);
		chk(v, 16'h0001);
		repeat (5) @(posedge clk_i);
		#1 chk({15'h0000, run}, 16'h0000);
		@(posedge clk_i); pend <= 7'h04; ien <= 7'h04;
		repeat (2) @(posedge clk_i);
		#1 chk({14'h0000, run, acc}, 16'h0002);
		@(posedge clk_i); master_int_enable <= 1'b1;
		#1 chk({15'h0000, acc}, 16'h0001);
		@(posedge clk_i); master_int_enable <= 1'b0; pend <= 7'h00; ien <= 7'h00;
		rd(4'h1);
		chk(v, 16'h0000);
	end
	endtask
	task t_deep;
	begin
		@(posedge clk_i); hsel <= 1'b1; mode <= 2'h2;
		rd(4'h2);
		chk(v, 16'h0004);
		wr(4'h1, 16'h0002);
		#1 chk({14'h0000, run, prun}, 16'h0000);
		chk({14'h0000, rco, hcv}, 16'h0000);
		repeat (2) @(posedge clk_i);
		@(posedge clk_i); wdt <= 1'b1;
		@(posedge clk_i); wdt <= 1'b0;
		wake;
		chk({14'h0000, n > 2100 && n < 2400, shs}, 16'h0003);
		chk({14'h0000, rco, hcv}, 16'h0003);
		wait_ext;
	end
	endtask
	task t_halth;
	begin
		@(posedge clk_i); mode <= 2'h1;
		rd(4'h2);
		chk(v, 16'h0006);
		wr(4'h1, 16'h0004);
		#1 chk({14'h0000, run, lso}, 16'h0001);
		@(posedge clk_i); pend <= 7'h01; ien <= 7'h01;
		wake;
		chk({15'h0000, shs}, 16'h0001);
		@(posedge clk_i); pend <= 7'h00; ien <= 7'h00;
		wait_ext;
	end
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		bw <= 1'b1;
		t_blocks;
		t_halt;
		t_deep;
		t_halth;
		test_done;
	end
endmodule // standby_block_power_control_tb
